// file: hdl/vim_device.sv
// Voltage input module data path and register map slave end
//
// Operation
// - Process value is one unsigned 16-bit word
// - 12-bit value in top bits, low four empty
// - Allocated input words read with code 4
// - Allocated data also in holding area, code 3
// - Slot process value at 256 plus slot
// - Status bits at 2048 plus 8*slot plus bit-8
// - Status word 768, type word 1024, per slot
// - Direct and legacy numbering both reach data
// - No line fault detection, never reported
// - Normal forwards live, simulation forwards simulated value
// - Current value mode forwards field signal unchanged
// - Substitute mode forwards substitute, flagged invalid
// - Last valid mode holds value before fault
// - Channel active only while module enabled
// - Sim and substitute limited to -25..125 percent
// - Rate filter off at zero, else limits slope
`timescale 1ns/1ps
module vim_device #(
  parameter int          TICK_LEN   = vim_pkg::TICK_CYCLES,
  parameter logic [15:0] SLOT       = 16'h0000,
  parameter logic [15:0] ALLOC_ADDR = 16'h0000,
  parameter logic [15:0] TYPE_CODE  = 16'h00a5  // Arbitrary type code value
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Link to master
  vim_link_if.dev_mp               link,
  // Field measurement
  input  wire logic [11:0]         meas_value,
  input  wire logic                meas_fault,
  // Module settings
  input  wire logic                module_enable,
  input  wire logic                sim_mode,
  input  wire vim_pkg::vim_err_type err_mode,
  input  wire logic signed [15:0]  sim_pct,
  input  wire logic                sim_invalid,
  input  wire logic signed [15:0]  subst_pct,
  input  wire logic [15:0]         rate_pct_s,
  // Channel result
  output logic [15:0]              chan_word,
  output logic [15:0]              status_word
);
  // ==========================================================
  // Helpers
  // Clamp percent to the accepted span and convert to points
  function automatic logic [15:0] pct_to_word(input logic signed [15:0] p);
    logic signed [15:0] c;
    logic [17:0]        pts;
    c = p;
    if (c < vim_pkg::PCT_MIN) begin
      c = vim_pkg::PCT_MIN;
    end
    if (c > vim_pkg::PCT_MAX) begin
      c = vim_pkg::PCT_MAX;
    end
    pts = 18'(signed'(18'(c)) * signed'({15'h0000, vim_pkg::PTS_PER_HUNDREDTH}))
          + vim_pkg::PTS_ZERO;
    return pts[15:0] & vim_pkg::VALUE_MASK;
  endfunction

  // True when the address equals the area base plus the given index
  function automatic logic in_area(input logic [15:0] a, input logic [15:0] base,
                                   input logic [15:0] idx);
    return a == base + idx;
  endfunction

  // ==========================================================
  // Field input synchroniser
  // The converter runs on its own timing, so value and fault pass two
  // flip-flops before any logic reads them. Limitation: the word is not
  // gray coded, so the converter must hold it steady for three cycles
  logic [11:0] meas_meta_q;
  logic [11:0] meas_sync_q;
  logic        fault_meta_q;
  logic        fault_sync_q;

  // Two stage capture; value and fault move together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_meta_q  <= 12'h000;
      meas_sync_q  <= 12'h000;
      fault_meta_q <= 1'b0;
      fault_sync_q <= 1'b0;
    end else begin
      meas_meta_q  <= meas_value;
      meas_sync_q  <= meas_meta_q;
      fault_meta_q <= meas_fault;
      fault_sync_q <= fault_meta_q;
    end
  end

  // ==========================================================
  // Rate filter
  logic [31:0] tick_cnt_q;
  logic [15:0] filt_q;
  wire  [15:0] live_word = 16'(meas_sync_q) << vim_pkg::VALUE_LSB;
  wire         tick      = tick_cnt_q == 32'(TICK_LEN - 1);
  wire  [17:0] step      = 18'(rate_pct_s) * 18'(vim_pkg::STEP_PER_RATE);
  // Upper limit gets a spare bit so a large rate cannot wrap around
  wire  [18:0] up_lim    = 19'(filt_q) + 19'(step);
  wire  [17:0] dn_lim    = (18'(filt_q) > step) ? 18'(filt_q) - step : 18'h00000;
  wire  [15:0] filt_d    = (19'(live_word) > up_lim) ? up_lim[15:0] :
                           (18'(live_word) < dn_lim) ? dn_lim[15:0] : live_word;
  wire  [15:0] field_word = (rate_pct_s == 16'h0000) ? live_word
                                                     : (filt_q & vim_pkg::VALUE_MASK);

  // Tick divider and slope limited follower
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
      filt_q     <= 16'h0000;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (rate_pct_s == 16'h0000) begin
        filt_q <= live_word;
      end else if (tick) begin
        filt_q <= filt_d;
      end
    end
  end

  // ==========================================================
  // Operating and error mode selection
  logic [15:0] last_valid_q;
  wire  [15:0] sim_word   = pct_to_word(sim_pct);
  wire  [15:0] subst_word = pct_to_word(subst_pct);
  wire         fault_act  = fault_sync_q && !sim_mode;
  wire  [15:0] err_word   = (err_mode == vim_pkg::ERR_SUBST) ? subst_word :
                            (err_mode == vim_pkg::ERR_LAST)  ? last_valid_q :
                            field_word;
  wire  [15:0] mode_word  = sim_mode  ? sim_word :
                            fault_act ? err_word : field_word;
  wire         invalid    = (sim_mode && sim_invalid) ||
                            (fault_act && err_mode == vim_pkg::ERR_SUBST);
  wire  [15:0] word_d     = module_enable ? mode_word : 16'h0000;
  wire  [15:0] stat_d     = 16'(module_enable & invalid) << vim_pkg::ST_INVALID
                          | 16'(module_enable & fault_act) << vim_pkg::ST_FAULT
                          | 16'(module_enable & sim_mode) << vim_pkg::ST_SIM
                          | 16'(!module_enable) << vim_pkg::ST_INACTIVE;
  // Line fault bit stays zero: no wiring check exists

  // Capture of channel word, status and last healthy value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_valid_q <= 16'h0000;
      chan_word    <= 16'h0000;
      status_word  <= 16'h0000;
    end else begin
      if (!fault_sync_q) begin
        last_valid_q <= field_word;
      end
      chan_word   <= word_d;
      status_word <= stat_d;
    end
  end

  // ==========================================================
  // Address decode for both numbering schemes
  wire        leg  = link.req_legacy;
  wire [15:0] a    = link.req_addr;
  wire [15:0] b_ai = leg ? vim_pkg::LEG_ALLOC_INPUT : vim_pkg::DIR_ALLOC_INPUT;
  wire [15:0] b_sv = leg ? vim_pkg::LEG_SLOT_VALUE  : vim_pkg::DIR_SLOT_VALUE;
  wire [15:0] b_ss = leg ? vim_pkg::LEG_SLOT_STATUS : vim_pkg::DIR_SLOT_STATUS;
  wire [15:0] b_st = leg ? vim_pkg::LEG_SLOT_TYPE   : vim_pkg::DIR_SLOT_TYPE;
  wire [15:0] b_ah = leg ? vim_pkg::LEG_ALLOC_HOLD  : vim_pkg::DIR_ALLOC_HOLD;
  wire [15:0] b_sb = leg ? vim_pkg::LEG_STATUS_BITS : vim_pkg::DIR_STATUS_BITS;
  wire [15:0] bit_base = b_sb + 16'(vim_pkg::BITS_PER_SLOT) * SLOT;
  wire [15:0] bit_off  = a - bit_base;
  wire        bit_hit  = a >= bit_base && bit_off < 16'(vim_pkg::BITS_PER_SLOT);
  wire [15:0] bit_val  = 16'(status_word[vim_pkg::ST_INVALID + 32'(bit_off[2:0])]);
  wire        fc_in    = link.req_fc == vim_pkg::FC_READ_INPUT;
  wire        fc_hold  = link.req_fc == vim_pkg::FC_READ_HOLDING;
  wire        fc_bits  = link.req_fc == vim_pkg::FC_READ_BITS;
  wire        hit_ai   = fc_in && in_area(a, b_ai, ALLOC_ADDR);
  wire        hit_sv   = fc_in && in_area(a, b_sv, SLOT);
  wire        hit_ss   = fc_in && in_area(a, b_ss, SLOT);
  wire        hit_st   = fc_in && in_area(a, b_st, SLOT);
  wire        hit_ah   = fc_hold && in_area(a, b_ah, ALLOC_ADDR);
  wire        hit_sb   = fc_bits && bit_hit;
  wire        fc_ok    = fc_in || fc_hold || fc_bits;
  wire        any_hit  = hit_ai || hit_sv || hit_ss || hit_st || hit_ah || hit_sb;
  wire [15:0] rd_data  = (hit_ai || hit_sv || hit_ah) ? chan_word :
                         hit_ss ? status_word :
                         hit_st ? TYPE_CODE :
                         hit_sb ? bit_val : 16'h0000;
  wire [15:0] exc_data = fc_ok ? 16'(vim_pkg::EXC_ILLEGAL_ADR)
                               : 16'(vim_pkg::EXC_ILLEGAL_FC);
  wire        take     = link.req_valid && !link.rsp_valid;

  // One answer per request, one cycle after it is taken
  // A request still high while its answer shows is not taken twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_exc   <= 1'b0;
      link.rsp_data  <= 16'h0000;
    end else begin
      link.rsp_valid <= take;
      if (take) begin
        link.rsp_exc  <= !any_hit;
        link.rsp_data <= any_hit ? rd_data : exc_data;
      end
    end
  end
endmodule

// file: hdl/vim_pkg.sv
// Shared constants and types for the voltage input register map link
package vim_pkg;
  // ==========================================================
  // Function codes and exception codes
  localparam logic [7:0] FC_READ_BITS    = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT   = 8'h04;
  localparam logic [7:0] EXC_ILLEGAL_FC  = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADR = 8'h02;
  // ==========================================================
  // Area bases, direct offset scheme
  localparam logic [15:0] DIR_ALLOC_INPUT = 16'h0000;
  localparam logic [15:0] DIR_SLOT_VALUE  = 16'h0100;
  localparam logic [15:0] DIR_SLOT_STATUS = 16'h0300;
  localparam logic [15:0] DIR_SLOT_TYPE   = 16'h0400;
  localparam logic [15:0] DIR_ALLOC_HOLD  = 16'h0600;
  localparam logic [15:0] DIR_STATUS_BITS = 16'h0800;
  // Area bases, legacy offset scheme (30001, 35000, 35200, 35300, 16200, 14001)
  localparam logic [15:0] LEG_ALLOC_INPUT = 16'h7531;
  localparam logic [15:0] LEG_SLOT_VALUE  = 16'h88b8;
  localparam logic [15:0] LEG_SLOT_STATUS = 16'h8980;
  localparam logic [15:0] LEG_SLOT_TYPE   = 16'h89e4;
  localparam logic [15:0] LEG_ALLOC_HOLD  = 16'h3f48;
  localparam logic [15:0] LEG_STATUS_BITS = 16'h36b1;
  localparam int          BITS_PER_SLOT   = 8;
  // ==========================================================
  // Channel word and status word layout
  localparam int          VALUE_LSB       = 4;
  localparam logic [15:0] VALUE_MASK      = 16'hfff0;
  localparam int          ST_INVALID      = 8;
  localparam int          ST_FAULT        = 9;
  localparam int          ST_SIM          = 10;
  localparam int          ST_INACTIVE     = 11;
  localparam int          ST_LINE_FAULT   = 12;
  // Percent in hundredths: -25.00 % .. 125.00 %, 400 points per percent
  localparam logic signed [15:0] PCT_MIN  = -16'sd2500;
  localparam logic signed [15:0] PCT_MAX  = 16'sd12500;
  localparam logic [17:0]        PTS_ZERO = 18'h02710;
  localparam logic [2:0]         PTS_PER_HUNDREDTH = 3'h4;
  // Rate filter tick: 10 ms at 100 MHz; step per tick is rate * 4 points
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          TICK_MS         = 10;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam logic [2:0]  STEP_PER_RATE   = 3'h4;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {ERR_CURRENT, ERR_SUBST, ERR_LAST} vim_err_type;
  // Host APB register offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int         CMD_GO     = 8;
  localparam int         CMD_LEGACY = 9;
endpackage

// file: hdl/vim_link_if.sv
// Request and answer link between register map master and device
`timescale 1ns/1ps
interface vim_link_if;
  logic        req_valid;
  logic [7:0]  req_fc;
  logic        req_legacy;
  logic [15:0] req_addr;
  logic        rsp_valid;
  logic        rsp_exc;
  logic [15:0] rsp_data;
  modport dev_mp  (input req_valid, req_fc, req_legacy, req_addr,
                   output rsp_valid, rsp_exc, rsp_data);
  modport host_mp (output req_valid, req_fc, req_legacy, req_addr,
                   input rsp_valid, rsp_exc, rsp_data);
endinterface

// file: hdl/vim_host.sv
// Register map master end, driven by software over APB
`timescale 1ns/1ps
module vim_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to device
  vim_link_if.host_mp      link
);
  // ==========================================================
  // Register state
  logic [7:0]  fc_q;
  logic        legacy_q;
  logic [15:0] addr_q;
  logic [15:0] result_q;
  logic        done_q;
  logic        exc_q;

  // Decode of APB access
  wire acc     = psel && penable;
  wire hit_cmd = paddr == vim_pkg::REG_CMD;
  wire hit_adr = paddr == vim_pkg::REG_ADDR;
  wire hit_res = paddr == vim_pkg::REG_RESULT;
  wire hit_sta = paddr == vim_pkg::REG_STATUS;
  wire mapped  = hit_cmd || hit_adr || hit_res || hit_sta;
  wire wr      = acc && pwrite && mapped;
  // Go while busy is ignored, so a running read is never disturbed
  wire go      = wr && hit_cmd && pwdata[vim_pkg::CMD_GO] && !link.req_valid;
  wire [31:0] rd_mux = hit_cmd ? {22'h0, legacy_q, 1'b0, fc_q} :
                       hit_adr ? {16'h0, addr_q} :
                       hit_res ? {16'h0, result_q} :
                       hit_sta ? {29'h0, exc_q, done_q, link.req_valid} : 32'h0;

  // Zero wait state slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = rd_mux;

  // Command and address capture, only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_q     <= 8'h00;
      legacy_q <= 1'b0;
      addr_q   <= 16'h0000;
    end else if (wr && !link.req_valid) begin
      if (hit_cmd) begin
        fc_q     <= pwdata[7:0];
        legacy_q <= pwdata[vim_pkg::CMD_LEGACY];
      end
      if (hit_adr) begin
        addr_q <= pwdata[15:0];
      end
    end
  end

  // Request holds until the answer arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.req_valid <= 1'b0;
      result_q       <= 16'h0000;
      done_q         <= 1'b0;
      exc_q          <= 1'b0;
    end else begin
      if (go) begin
        link.req_valid <= 1'b1;
        done_q         <= 1'b0;
      end else if (link.req_valid && link.rsp_valid) begin
        link.req_valid <= 1'b0;
        result_q       <= link.rsp_data;
        exc_q          <= link.rsp_exc;
        done_q         <= 1'b1;
      end
    end
  end

  // Request fields come straight from the held registers
  assign link.req_fc     = fc_q;
  assign link.req_legacy = legacy_q;
  assign link.req_addr   = addr_q;
endmodule

// file: tb/vim_monitor.sv
// Concurrent checks on the link between the two register map ends
`timescale 1ns/1ps
module vim_monitor #(
  parameter logic [15:0] SLOT      = 16'h0000,
  parameter logic [15:0] TYPE_CODE = 16'h00a5  // Arbitrary type code value
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Link signals
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_fc,
  input  wire logic        req_legacy,
  input  wire logic [15:0] req_addr,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_exc,
  input  wire logic [15:0] rsp_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Request decode, named so each property reads as one line
  wire logic        take     = req_valid && !rsp_valid;
  wire logic        rd4      = take && (req_fc == vim_pkg::FC_READ_INPUT);
  wire logic        good_fc  = (req_fc == vim_pkg::FC_READ_BITS) ||
                               (req_fc == vim_pkg::FC_READ_HOLDING) || rd4;
  wire logic [15:0] type_adr = (req_legacy ? vim_pkg::LEG_SLOT_TYPE
                                           : vim_pkg::DIR_SLOT_TYPE) + SLOT;
  wire logic [15:0] val_adr  = (req_legacy ? vim_pkg::LEG_SLOT_VALUE
                                           : vim_pkg::DIR_SLOT_VALUE) + SLOT;
  wire logic [15:0] line_adr = vim_pkg::DIR_STATUS_BITS + (SLOT << 3) + 16'h0004;
  // ==========================================================
  // Handshake steps: taken, one answer pulse, host lets go
  sequence s_take;
    take;
  endsequence
  sequence s_answer;
    rsp_valid ##1 (!rsp_valid && !req_valid);
  endsequence
  AST_TAKE_ANSWER: assert property (s_take |=> s_answer)
    else $error("link answer missing or not a single pulse");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(take))
    else $error("answer without a pending request");
  AST_DATA_HOLD: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("read data moved between answers");
  // ==========================================================
  // Data content of selected answers
  AST_BAD_FC: assert property (take && !good_fc |=> rsp_exc && rsp_data == 16'h0001)
    else $error("bad function code not refused");
  AST_BAD_ADDR: assert property (rd4 && !req_legacy && req_addr[15:8] == 8'h05
    |=> rsp_exc && rsp_data == 16'h0002) else $error("unmapped word not refused");
  AST_TYPE: assert property (rd4 && req_addr == type_adr
    |=> !rsp_exc && rsp_data == TYPE_CODE) else $error("type word wrong");
  AST_LOW_NIBBLE: assert property (rd4 && req_addr == val_adr
    |=> !rsp_exc && rsp_data[3:0] == 4'h0) else $error("low nibble of value not empty");
  AST_NO_LINE_FAULT: assert property (take && req_fc == vim_pkg::FC_READ_BITS &&
    !req_legacy && req_addr == line_adr |=> rsp_valid && !rsp_exc && !rsp_data[0])
    else $error("line fault bit reported");
  AST_STATUS_NO_LINE: assert property (rd4 && !req_legacy &&
    req_addr == vim_pkg::DIR_SLOT_STATUS + SLOT |=> !rsp_data[vim_pkg::ST_LINE_FAULT])
    else $error("line fault set in status word");
endmodule

// file: tb/tb_top.sv
// Self-checking bench: APB software side, both link ends, field inputs
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Settings, stimulus and observed signals
  localparam logic [15:0] SLOT  = 16'h0003;
  localparam logic [15:0] ALLOC = 16'h0005;
  localparam logic [15:0] TYPE  = 16'h005a;  // Arbitrary type code value
  localparam logic [7:0]  F2    = vim_pkg::FC_READ_BITS;
  localparam logic [7:0]  F4    = vim_pkg::FC_READ_INPUT;
  localparam logic [15:0] VD    = vim_pkg::DIR_SLOT_VALUE + SLOT;
  localparam logic [15:0] VL    = vim_pkg::LEG_SLOT_VALUE + SLOT;
  localparam logic [15:0] BD    = vim_pkg::DIR_STATUS_BITS + (SLOT << 3);
  localparam logic [15:0] BL    = vim_pkg::LEG_STATUS_BITS + (SLOT << 3);
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e;
  logic [11:0] meas = 12'h000;
  logic fault = 1'b0, en = 1'b0, sim = 1'b0, sim_inv = 1'b0;
  vim_pkg::vim_err_type emode = vim_pkg::ERR_CURRENT;
  logic signed [15:0] sim_pct = 16'sh0000, subst_pct = 16'sh0000;
  logic [15:0] rate = 16'h0000, chan_word, status_word;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  // ==========================================================
  // Clock and the two joined ends
  always #5 pclk = ~pclk;
  vim_link_if link ();
  vim_host vim_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  vim_device #(.TICK_LEN(10), .SLOT(SLOT), .ALLOC_ADDR(ALLOC), .TYPE_CODE(TYPE)) vim_device_inst (
    .pclk(pclk), .presetn(presetn), .link(link), .meas_value(meas), .meas_fault(fault),
    .module_enable(en), .sim_mode(sim), .err_mode(emode), .sim_pct(sim_pct),
    .sim_invalid(sim_inv), .subst_pct(subst_pct), .rate_pct_s(rate),
    .chan_word(chan_word), .status_word(status_word));
  vim_monitor #(.SLOT(SLOT), .TYPE_CODE(TYPE)) vim_monitor_inst (.pclk(pclk),
    .presetn(presetn), .req_valid(link.req_valid), .req_fc(link.req_fc),
    .req_legacy(link.req_legacy), .req_addr(link.req_addr), .rsp_valid(link.rsp_valid),
    .rsp_exc(link.rsp_exc), .rsp_data(link.rsp_data));
  // ==========================================================
  // Verdict, comparison and access tasks
  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Register map read through the host; bit reads keep only bit 0
  task automatic rd(input logic [7:0] fc, input logic leg, input logic [15:0] a,
                    input logic [15:0] exp, input logic xe);
    int n;
    n = 0;
    apb(1'b1, vim_pkg::REG_ADDR, {16'h0000, a});
    apb(1'b1, vim_pkg::REG_CMD, {22'h0, leg, 1'b1, fc});
    do begin
      apb(1'b0, vim_pkg::REG_STATUS, 32'h0);
      n++;
    end while (r[1] !== 1'b1 && n < 40);
    chk({15'h0, r[1]}, 16'h0001);
    chk({15'h0, r[2]}, {15'h0, xe});
    apb(1'b0, vim_pkg::REG_RESULT, 32'h0);
    chk((fc == F2 && !xe) ? {15'h0, r[0]} : r[15:0], exp);
  endtask
  // Field and mode settings, then let the channel word settle
  task automatic cfg(input logic n, input logic s, input vim_pkg::vim_err_type m,
                     input logic f, input logic [11:0] v);
    @(posedge pclk);
    en    <= n;
    sim   <= s;
    emode <= m;
    fault <= f;
    meas  <= v;
    repeat (4) @(posedge pclk);
  endtask
  // Hang guard, far above the roughly 1100 cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, vim_pkg::REG_STATUS, 32'h0);
    chk(r[15:0], 16'h0000);
    apb(1'b0, 8'h10, 32'h0);
    chk({15'h0, e}, 16'h0001);
    // Full scale value through every area and both numberings
    cfg(1'b1, 1'b0, vim_pkg::ERR_CURRENT, 1'b0, 12'hfff);
    rd(F4, 1'b0, VD, 16'hfff0, 1'b0);
    rd(F4, 1'b1, VL, 16'hfff0, 1'b0);
    rd(F4, 1'b0, vim_pkg::DIR_ALLOC_INPUT + ALLOC, 16'hfff0, 1'b0);
    rd(F4, 1'b1, vim_pkg::LEG_ALLOC_INPUT + ALLOC, 16'hfff0, 1'b0);
    rd(8'h03, 1'b0, vim_pkg::DIR_ALLOC_HOLD + ALLOC, 16'hfff0, 1'b0);
    rd(8'h03, 1'b1, vim_pkg::LEG_ALLOC_HOLD + ALLOC, 16'hfff0, 1'b0);
    rd(F4, 1'b0, vim_pkg::DIR_SLOT_STATUS + SLOT, 16'h0000, 1'b0);
    rd(F4, 1'b1, vim_pkg::LEG_SLOT_TYPE + SLOT, TYPE, 1'b0);
    // Simulation values, flagged invalid, with clamping at both ends
    sim_pct <= 16'sd5000;
    sim_inv <= 1'b1;
    cfg(1'b1, 1'b1, vim_pkg::ERR_CURRENT, 1'b0, 12'h123);
    rd(F4, 1'b0, VD, 16'h7530, 1'b0);
    rd(F2, 1'b0, BD, 16'h0001, 1'b0);
    rd(F2, 1'b1, BL + 16'h0002, 16'h0001, 1'b0);
    rd(F2, 1'b0, BD + 16'h0004, 16'h0000, 1'b0);
    sim_pct <= 16'sd16000;
    cfg(1'b1, 1'b1, vim_pkg::ERR_CURRENT, 1'b0, 12'h123);
    rd(F4, 1'b0, VD, 16'hea60, 1'b0);
    sim_pct <= -16'sd3000;
    cfg(1'b1, 1'b1, vim_pkg::ERR_CURRENT, 1'b0, 12'h123);
    rd(F4, 1'b0, VD, 16'h0000, 1'b0);
    // Each error mode while a fault is present
    cfg(1'b1, 1'b0, vim_pkg::ERR_CURRENT, 1'b1, 12'h456);
    rd(F4, 1'b0, VD, 16'h4560, 1'b0);
    cfg(1'b1, 1'b0, vim_pkg::ERR_SUBST, 1'b1, 12'h456);
    rd(F4, 1'b0, VD, 16'h2710, 1'b0);
    rd(F2, 1'b0, BD, 16'h0001, 1'b0);
    cfg(1'b1, 1'b0, vim_pkg::ERR_LAST, 1'b0, 12'h777);
    cfg(1'b1, 1'b0, vim_pkg::ERR_LAST, 1'b1, 12'h888);
    rd(F4, 1'b0, VD, 16'h7770, 1'b0);
    // Disabled module, then a slow ramp with the rate filter on
    cfg(1'b0, 1'b0, vim_pkg::ERR_CURRENT, 1'b0, 12'h999);
    chk(status_word, 16'h0001 << vim_pkg::ST_INACTIVE);
    rd(F4, 1'b0, VD, 16'h0000, 1'b0);
    rd(F2, 1'b0, BD + 16'h0003, 16'h0001, 1'b0);
    rate <= 16'h0064;
    cfg(1'b1, 1'b0, vim_pkg::ERR_CURRENT, 1'b0, 12'hfff);
    samples_checked++;
    if ((chan_word < 16'hfff0) !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected below %h", $time, chan_word, 16'hfff0);
    end
    // 400 points per tick closes the gap well inside 800 cycles
    repeat (800) @(posedge pclk);
    chk(chan_word, 16'hfff0);
    // Refused requests
    rd(8'h05, 1'b0, VD, 16'h0001, 1'b1);
    rd(F4, 1'b0, 16'h0520, 16'h0002, 1'b1);
    close_out;
  end
endmodule
